/* hw/ppmc_pkg.sv */
package ppmc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] PPMC_IDX_PIN1 = 32'h5000_3008;
  localparam logic [31:0] PPMC_IDX_PIN2 = 32'h5000_300A;
  localparam logic [31:0] PPMC_IDX_PIN3 = 32'h5000_300C;
  localparam logic [31:0] PPMC_IDX_PIN4 = 32'h5000_300E;
  localparam logic [31:0] PPMC_IDX_PIN5 = 32'h5000_3010;
  localparam logic [31:0] PPMC_IDX_PIN6 = 32'h5000_3012;
  localparam logic [31:0] PPMC_IDX_PIN7 = 32'h5000_3014;
  localparam logic [31:0] PPMC_IDX_PIN8 = 32'h5000_3016;
  localparam logic [31:0] PPMC_IDX [8] = '{PPMC_IDX_PIN1, PPMC_IDX_PIN2, PPMC_IDX_PIN3, PPMC_IDX_PIN4,
                                           PPMC_IDX_PIN5, PPMC_IDX_PIN6, PPMC_IDX_PIN7, PPMC_IDX_PIN8};
  localparam int          PPMC_MAX_PIN  = 8;
  // only the low index bits are decoded; paddr[11:2] against index[9:0]
  localparam int          PPMC_ADDR_W   = 12;
  localparam int          PPMC_IDX_W    = 10;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          PPMC_PULL_LSB = 8;
  localparam int          PPMC_FUNC_LSB = 0;
  localparam int          PPMC_PULL_W   = 2;
  localparam int          PPMC_FUNC_W   = 5;
  localparam logic [1:0]  PPMC_PULL_RST = 2'h2;
  localparam logic [4:0]  PPMC_FUNC_RST = 5'h00;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  PPMC_PULL_NONE = 2'h0;
  localparam logic [1:0]  PPMC_PULL_UP   = 2'h1;
  localparam logic [1:0]  PPMC_PULL_DOWN = 2'h2;
  localparam logic [1:0]  PPMC_PULL_OUT  = 2'h3;
  localparam logic [4:0]  PPMC_FN_GPIO   = 5'h00;
  localparam logic [4:0]  PPMC_FN_ADC    = 5'h0F;
  localparam logic [31:0] PPMC_FN_RSVD   = 32'h8060_4180;
  localparam logic [7:0]  PPMC_ADC_PINS  = 8'h63;

  typedef struct packed {
    logic [PPMC_PULL_W-1:0] pull;
    logic [PPMC_FUNC_W-1:0] func;
  } ppmc_cfg_t;

  typedef struct packed {
    logic drive;
    logic dout;
    logic pu;
    logic pd;
    logic ana;
  } ppmc_pad_t;

  localparam ppmc_cfg_t PPMC_CFG_RST = '{pull: PPMC_PULL_RST, func: PPMC_FUNC_RST};

endpackage

/* hw/ppmc_pin.sv */
`timescale 1ns/1ps

module ppmc_pin
  import ppmc_pkg::*;
#(
  parameter bit ADC_OK = 1'b0
) (
  input  wire ppmc_cfg_t   cfg,
  input  wire logic        gpio_do,
  input  wire logic [31:0] periph_out,
  input  wire logic [31:0] periph_oe,
  output ppmc_pad_t        pad
);

  logic is_adc;
  logic is_rsvd;

  // (R6) adc code only on capable pins
  assign is_adc  = ADC_OK && (cfg.func == PPMC_FN_ADC);
  assign is_rsvd = PPMC_FN_RSVD[cfg.func] || (!ADC_OK && (cfg.func == PPMC_FN_ADC));

  always_comb begin
    pad = '0;
    if (is_adc) begin
      // (R4) adc ignores pull field
      pad.ana = 1'b1;
    end else begin
      // (R1) pull field decode
      pad.pu = (cfg.pull == PPMC_PULL_UP);
      pad.pd = (cfg.pull == PPMC_PULL_DOWN);
      if (cfg.func == PPMC_FN_GPIO) begin
        // (R2) only code 11 drives
        pad.drive = (cfg.pull == PPMC_PULL_OUT);
        pad.dout  = gpio_do;
      end else if (!is_rsvd) begin
        // (R5) peripheral owns the pad
        pad.drive = periph_oe[cfg.func];
        pad.dout  = periph_out[cfg.func];
      end
    end
  end

endmodule

/* hw/ppmc_top.sv */
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

// Function
// (R1) pull field 00 none, 01 up, 10 down
// (R2) pull field 11 alone drives, no resistor
// (R3) pull field resets to pull-down
// (R4) analog function ignores the pull field
// (R5) function field selects gpio or peripheral
// (R6) analog on pins 1,2,6,7; reserved codes inert; code still applies the pull field and, except code 0F, routes the pin input to periph_in
// (R7) shared input function taken from lowest pin
// (R8) reserved bits read zero, ignore writes
module ppmc_top
  import ppmc_pkg::*;
#(
  parameter int NPIN = 8
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [PPMC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [NPIN-1:0]        pad_in,
  output logic      [NPIN-1:0]        pad_out,
  output logic      [NPIN-1:0]        pad_oe_n,
  output logic      [NPIN-1:0]        pad_pu,
  output logic      [NPIN-1:0]        pad_pd,
  output logic      [NPIN-1:0]        pad_ana,
  input  wire logic [NPIN-1:0]        gpio_do,
  output logic      [NPIN-1:0]        gpio_di,
  input  wire logic [31:0]            periph_out,
  input  wire logic [31:0]            periph_oe,
  output logic      [31:0]            periph_in
);

  if (NPIN < 1 || NPIN > PPMC_MAX_PIN) begin : g_bad_npin
    $error("ppmc_top: NPIN must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  ppmc_cfg_t       cfg_q [NPIN];
  logic [NPIN-1:0] hit;
  logic [31:0]     rdata_d;
  logic            setup;
  logic            wr_en;

  assign setup = psel && !penable;
  // write lands on the single access edge, pready is high only there
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    rdata_d = '0;
    for (int i = 0; i < NPIN; i++) begin
      hit[i] = (paddr[PPMC_ADDR_W-1:2] == PPMC_IDX[i][PPMC_IDX_W-1:0]);
      if (hit[i]) begin
        // (R8) reserved bits read zero
        rdata_d[PPMC_PULL_LSB +: PPMC_PULL_W] = cfg_q[i].pull;
        rdata_d[PPMC_FUNC_LSB +: PPMC_FUNC_W] = cfg_q[i].func;
      end
    end
  end

  // answer registered in setup so every bus output leaves a flop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && (hit == '0);
      prdata  <= (setup && !pwrite) ? rdata_d : '0;
    end
  end

  for (genvar i = 0; i < NPIN; i++) begin : g_reg
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        // (R3) pull-down at reset
        cfg_q[i] <= PPMC_CFG_RST;
      end else if (wr_en && hit[i]) begin
        // (R8) only defined fields stored
        if (pstrb[1]) begin
          cfg_q[i].pull <= pwdata[PPMC_PULL_LSB +: PPMC_PULL_W];
        end
        if (pstrb[0]) begin
          cfg_q[i].func <= pwdata[PPMC_FUNC_LSB +: PPMC_FUNC_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pad input synchroniser
  // ----------------------------------------------------------------
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] sync_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pad_in;
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------
  // per-pin mux and pad flops
  // ----------------------------------------------------------------
  ppmc_pad_t pad_d [NPIN];

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    ppmc_pin #(
      .ADC_OK (PPMC_ADC_PINS[i])
    ) u_pin (
      .cfg        (cfg_q[i]),
      .gpio_do    (gpio_do[i]),
      .periph_out (periph_out),
      .periph_oe  (periph_oe),
      .pad        (pad_d[i])
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        // (R3) reset pads as pulled-down inputs
        pad_out[i]  <= 1'b0;
        pad_oe_n[i] <= 1'b1;
        pad_pu[i]   <= 1'b0;
        pad_pd[i]   <= 1'b1;
        pad_ana[i]  <= 1'b0;
      end else begin
        pad_out[i]  <= pad_d[i].dout;
        pad_oe_n[i] <= !pad_d[i].drive;
        pad_pu[i]   <= pad_d[i].pu;
        pad_pd[i]   <= pad_d[i].pd;
        pad_ana[i]  <= pad_d[i].ana;
      end
    end
  end

  // ----------------------------------------------------------------
  // peripheral input routing
  // ----------------------------------------------------------------
  logic [31:0] route_d;

  always_comb begin
    route_d = '0;
    // (R7) scan downward, lowest pin wins
    for (int i = NPIN - 1; i >= 0; i--) begin
      if (cfg_q[i].func != PPMC_FN_GPIO && cfg_q[i].func != PPMC_FN_ADC) begin
        route_d[cfg_q[i].func] = sync_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      periph_in <= '0;
      gpio_di   <= '0;
    end else begin
      periph_in <= route_d;
      gpio_di   <= sync_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic seen_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  reset_pull_a: assert property (!seen_q |-> cfg_q[0].pull == 2'h2 && cfg_q[0].func == 5'h00 && pad_pd[0]) // (R3)
    else $error("pin1 not pulled-down input after reset");
  float_in_a: assert property (cfg_q[0].func == 5'h00 && cfg_q[0].pull == 2'h0 // (R1)
    |=> pad_oe_n[0] && !pad_pu[0] && !pad_pd[0]) else $error("pull 00 not floating input");
  pull_up_a: assert property (cfg_q[0].func == 5'h00 && cfg_q[0].pull == 2'h1 // (R1)
    |=> pad_oe_n[0] && pad_pu[0] && !pad_pd[0]) else $error("pull 01 not pull-up");
  pull_dn_a: assert property (cfg_q[0].func == 5'h00 && cfg_q[0].pull == 2'h2 // (R1)
    |=> pad_oe_n[0] && !pad_pu[0] && pad_pd[0]) else $error("pull 10 not pull-down");
  out_drive_a: assert property (cfg_q[0].func == 5'h00 && cfg_q[0].pull == 2'h3 // (R2)
    |=> !pad_oe_n[0] && !pad_pu[0] && !pad_pd[0] && pad_out[0] == $past(gpio_do[0]))
    else $error("pull 11 not driving gpio data");
  adc_ignore_a: assert property (cfg_q[0].func == 5'h0F // (R4)
    |=> pad_ana[0] && pad_oe_n[0] && !pad_pu[0] && !pad_pd[0]) else $error("adc pin not released");
  rsvd_code_a: assert property (PPMC_FN_RSVD[cfg_q[0].func] |=> pad_oe_n[0] && !pad_ana[0]) // (R6)
    else $error("reserved code drives pin");
  rd_zero_a: assert property (pready && !pwrite |-> prdata[31:10] == '0 && prdata[7:5] == '0) // (R8)
    else $error("reserved read bits not zero");
  wr_back_a: assert property (setup && pwrite && pstrb[1:0] == 2'h3 && paddr[11:2] == 10'h008 // (R5)
    ##1 penable && pready |=> cfg_q[0].func == $past(pwdata[4:0]) && cfg_q[0].pull == $past(pwdata[9:8]))
    else $error("pin1 write not stored");
  prio_a: assert property (cfg_q[0].func == 5'h1A |=> periph_in[26] == $past(sync_q[0])) // (R7)
    else $error("lowest pin not chosen for input");
  bad_addr_a: assert property (setup && hit == '0 |=> pready && pslverr) // (R5)
    else $error("unmapped address not flagged");

  wr_c: cover property (wr_en && hit[0]);
  rd_c: cover property (pready && !pwrite && !pslverr);
  adc_c: cover property (pad_ana[0]);
  drive_c: cover property (!pad_oe_n[0] ##1 pad_oe_n[0]);

endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import ppmc_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, periph_out, periph_oe, periph_in;
  logic [7:0]  pad_in, pad_out, pad_oe_n, pad_pu, pad_pd, pad_ana, gpio_do, gpio_di;
  logic [33:0] exp_q[$];
  logic [33:0] cur;
  logic [4:0]  rsv [6] = '{5'h07, 5'h08, 5'h0E, 5'h15, 5'h16, 5'h1F};
  int          err_total, n_checks, seed, n;

  always #2 clk_sys = ~clk_sys;

  ppmc_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pu(pad_pu), .pad_pd(pad_pd),
    .pad_ana(pad_ana), .gpio_do(gpio_do), .gpio_di(gpio_di), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in));

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", what, expv, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  function automatic logic [11:0] rga(input int i);
    return {PPMC_IDX[i][9:0], 2'h0};
  endfunction

  // e holds {error flag, read data}; released a full cycle apart so no double drive
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int k;
    exp_q.push_back({w, e});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      err_total++;
      close_out();
    end
    @(posedge clk_sys);
  endtask

  // reserved bits carry random junk
  task automatic wr(input int i, input logic [1:0] p, input logic [4:0] f);
    logic [31:0] d;
    d = $random(seed);
    d[9:8] = p;
    d[4:0] = f;
    xfer(1'b1, rga(i), d, 33'h0);
  endtask

  task automatic rd(input int i, input logic [31:0] v);
    xfer(1'b0, rga(i), $random(seed), {1'b0, v});
  endtask

  task automatic pads(input int i, input logic u, input logic dn, input logic oen, input logic an);
    @(negedge clk_sys);
    chk("pad_pu", pad_pu[i], u);
    chk("pad_pd", pad_pd[i], dn);
    chk("pad_oe_n", pad_oe_n[i], oen);
    chk("pad_ana", pad_ana[i], an);
    @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // answer monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("queue", 32'h1, 32'h0);
      end else begin
        cur = exp_q.pop_front();
        chk("pslverr", {31'h0, pslverr}, {31'h0, cur[32]});
        if (!cur[33]) chk("prdata", prdata, cur[31:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed      = 15;
    err_total = 0;
    n_checks  = 0;
    {rstn, psel, penable, pwrite, paddr, pwdata, pad_in, periph_out, periph_oe} <= '0;
    pstrb     <= 4'hF;
    gpio_do   <= 8'($random(seed));
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    for (n = 0; n < 8; n++) pads(n, 1'b0, 1'b1, 1'b1, 1'b0);
    for (n = 0; n < 8; n++) rd(n, 32'h0000_0200);
    // every pull code on pin one
    for (n = 0; n < 4; n++) begin
      wr(0, n[1:0], 5'h00);
      pads(0, n == 1, n == 2, n != 3, 1'b0);
      rd(0, {22'h0, n[1:0], 8'h00});
    end
    chk("pad_out", pad_out[0], gpio_do[0]);
    // flip the data so a stuck output shows
    gpio_do <= ~gpio_do;
    repeat (2) @(posedge clk_sys);
    chk("pad_out", pad_out[0], gpio_do[0]);
    // analog only where allowed, pull ignored there
    periph_oe <= 32'hFFFF_FFFF;
    for (n = 0; n < 8; n++) begin
      wr(n, 2'h2, PPMC_FN_ADC);
      pads(n, 1'b0, !PPMC_ADC_PINS[n], 1'b1, PPMC_ADC_PINS[n]);
      wr(n, 2'h2, 5'h00);
    end
    // reserved codes leave the pad inert even with every oe high
    foreach (rsv[j]) begin
      wr(0, 2'h3, rsv[j]);
      pads(0, 1'b0, 1'b0, 1'b1, 1'b0);
      wr(2, 2'h3, rsv[j]);
      pads(2, 1'b0, 1'b0, 1'b1, 1'b0);
    end
    // peripheral drives the pad
    periph_oe  <= 32'h0000_0004;
    periph_out <= $random(seed);
    wr(4, 2'h0, 5'h02);
    pads(4, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("pad_out", pad_out[4], periph_out[2]);
    // shared input function: lowest pin wins
    wr(1, 2'h0, 5'h1A);
    wr(3, 2'h0, 5'h1A);
    pad_in <= (8'($random(seed)) & 8'hF5) | 8'h08;
    repeat (4) @(posedge clk_sys);
    chk("periph_in", periph_in[26], 1'b0);
    chk("gpio_di", gpio_di, pad_in);
    chk("periph_in", {periph_in[15], periph_in[0]}, 2'h0);
    pad_in <= pad_in ^ 8'h0A;
    repeat (4) @(posedge clk_sys);
    chk("periph_in", periph_in[26], 1'b1);
    // pin one joins last and still takes priority
    pad_in <= pad_in & 8'hFE;
    wr(0, 2'h0, 5'h1A);
    repeat (4) @(posedge clk_sys);
    chk("periph_in", periph_in[26], 1'b0);
    // byte lane gating keeps the pull field
    pstrb <= 4'h1;
    wr(7, 2'h3, 5'h05);
    pstrb <= 4'hF;
    rd(7, 32'h0000_0205);
    // unmapped read and write refused
    xfer(1'b0, 12'h000, 32'h0, {1'b1, 32'h0});
    xfer(1'b1, 12'h100, 32'hFFFF_FFFF, {1'b1, 32'h0});
    rd(2, 32'h0000_031F);
    // reset in mid-run puts every pin back to a pulled-down input
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    for (n = 0; n < 8; n++) pads(n, 1'b0, 1'b1, 1'b1, 1'b0);
    rd(0, 32'h0000_0200);
    chk("queue", exp_q.size(), 32'h0);
    close_out();
  end
endmodule
